// File: wes_pkg.sv
package wes_pkg;

	// Power-management control/status word fields
	localparam logic [7:0] WES_PMCSR_OFFSET    = 8'h44;
	localparam int         WES_PMCSR_STATE_LSB = 0;
	localparam int         WES_PMCSR_STATE_W   = 2;
	localparam int         WES_PMCSR_PIN_EN    = 8;
	localparam int         WES_PMCSR_WAKE_FLAG = 15;

	// Wake miscellaneous configuration word fields
	localparam int WES_MISC_PATTERN_FLAG = 7;
	localparam int WES_MISC_LINK_MODE    = 8;
	localparam int WES_MISC_LINK_FLAG    = 9;
	localparam int WES_MISC_OVERRIDE     = 10;

	// Power states
	localparam logic [WES_PMCSR_STATE_W-1:0] WES_STATE_D0 = 2'h0;
	localparam logic [WES_PMCSR_STATE_W-1:0] WES_STATE_D3 = 2'h3;

	// Reset values
	localparam logic [WES_PMCSR_STATE_W-1:0] WES_RST_STATE     = WES_STATE_D0;
	localparam logic                         WES_RST_PIN_EN    = 1'h0;
	localparam logic                         WES_RST_LINK_MODE = 1'h0;
	localparam logic                         WES_RST_OVERRIDE  = 1'h0;

	localparam int WES_WORD_W = 16;

	// One configuration write: strobe and data
	typedef struct packed {
		logic                  wr;
		logic [WES_WORD_W-1:0] data;
	} wes_cfg_write_t;

	// Wake event inputs from detectors on the device clock
	typedef struct packed {
		logic magic_detect;
		logic pattern_detect;
		logic mii_mode;
	} wes_events_t;

endpackage

// File: wes_wake_event.sv
`timescale 1ns/1ps
module wes_wake_event
	import wes_pkg::*;
(
	// Clock and reset
	input  wire logic                             core_clk,
	input  wire logic                             reset,
	// Detector events
	input  wire wes_pkg::wes_events_t             events,
	// Link status pin
	input  wire logic                             link_status,
	// Configuration writes
	input  wire wes_pkg::wes_cfg_write_t          pmcsr_write,
	input  wire wes_pkg::wes_cfg_write_t          misc_write,
	input  wire wes_pkg::wes_cfg_write_t          eeprom_load,
	// Configuration read-back
	output logic [wes_pkg::WES_WORD_W-1:0]        pmcsr_rdata,
	output logic [wes_pkg::WES_WORD_W-1:0]        misc_rdata,
	output logic [wes_pkg::WES_PMCSR_STATE_W-1:0] power_state,
	// Wake outputs
	output logic                                  pme_out,
	output logic                                  pme_oe,
	output logic                                  remote_wake_output
);
	import wes_pkg::*;

	logic                           wake_event_flag;
	logic                           wake_pin_enable;
	logic                           pattern_match_flag;
	logic                           link_change_detected;
	logic                           link_change_mode;
	logic                           wake_enable_override;
	logic                           link_meta;
	logic                           link_sync;
	logic                           link_prev;
	logic                           link_prev_valid;
	logic [1:0]                     link_fill;
	logic                           link_edge;
	logic                           pattern_event;
	logic                           link_event;
	logic                           wake_clear;
	logic                           next_wake_event_flag;
	logic                           next_wake_pin_enable;
	logic                           next_pattern_match_flag;
	logic                           next_link_change_detected;
	logic                           next_link_change_mode;
	logic                           next_wake_enable_override;
	logic [WES_PMCSR_STATE_W-1:0]   next_power_state;
	logic                           next_pme;

	// Sticky flag update, set beats clear
	function automatic logic sticky(input logic cur, input logic clr, input logic set);
		sticky = set | (cur & ~clr);
	endfunction

	// Link status crosses from the pin domain
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_meta <= 1'h0;
			link_sync <= 1'h0;
		end else begin
			link_meta <= link_status;
			link_sync <= link_meta;
		end
	end

	// Previous sample; no edge until the sync chain holds pin data
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_prev       <= 1'h0;
			link_fill       <= 2'h0;
			link_prev_valid <= 1'h0;
		end else begin
			link_prev       <= link_sync;
			link_fill       <= {link_fill[0], 1'h1};
			link_prev_valid <= link_fill[1];
		end
	end

	always_comb begin
		link_edge     = link_prev_valid && (link_sync != link_prev);
		pattern_event = events.pattern_detect && events.mii_mode;
		link_event    = link_edge && link_change_mode && events.mii_mode;
		wake_clear    = pmcsr_write.wr && !pmcsr_write.data[WES_PMCSR_WAKE_FLAG];

		next_pattern_match_flag = sticky(pattern_match_flag,
			misc_write.wr && misc_write.data[WES_MISC_PATTERN_FLAG], pattern_event);
		next_link_change_detected = sticky(link_change_detected,
			misc_write.wr && misc_write.data[WES_MISC_LINK_FLAG], link_event);
		next_wake_event_flag = sticky(wake_event_flag, wake_clear,
			events.magic_detect || pattern_event || link_event);

		next_wake_pin_enable = pmcsr_write.wr ? pmcsr_write.data[WES_PMCSR_PIN_EN]
			: wake_pin_enable;
		next_power_state = pmcsr_write.wr
			? pmcsr_write.data[WES_PMCSR_STATE_LSB +: WES_PMCSR_STATE_W] : power_state;

		next_link_change_mode = link_change_mode;
		next_wake_enable_override = wake_enable_override;
		if (eeprom_load.wr) begin
			next_link_change_mode     = eeprom_load.data[WES_MISC_LINK_MODE];
			next_wake_enable_override = eeprom_load.data[WES_MISC_OVERRIDE];
		end
		if (misc_write.wr) begin
			next_link_change_mode     = misc_write.data[WES_MISC_LINK_MODE];
			next_wake_enable_override = misc_write.data[WES_MISC_OVERRIDE];
		end

		// Flag state and power state are independent, so clear and D0 may come in any order
		next_pme = next_wake_event_flag && (next_wake_pin_enable
			|| (next_wake_enable_override && next_link_change_detected));
	end

	// Sticky flags
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wake_event_flag      <= 1'h0;
			pattern_match_flag   <= 1'h0;
			link_change_detected <= 1'h0;
		end else begin
			wake_event_flag      <= next_wake_event_flag;
			pattern_match_flag   <= next_pattern_match_flag;
			link_change_detected <= next_link_change_detected;
		end
	end

	// Software controls
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wake_pin_enable      <= WES_RST_PIN_EN;
			power_state          <= WES_RST_STATE;
			link_change_mode     <= WES_RST_LINK_MODE;
			wake_enable_override <= WES_RST_OVERRIDE;
		end else begin
			wake_pin_enable      <= next_wake_pin_enable;
			power_state          <= next_power_state;
			link_change_mode     <= next_link_change_mode;
			wake_enable_override <= next_wake_enable_override;
		end
	end

	// Wake pins, clocked only by the device clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pme_out            <= 1'h0;
			pme_oe             <= 1'h0;
			remote_wake_output <= 1'h0;
		end else begin
			pme_out            <= 1'h0;
			pme_oe             <= next_pme;
			remote_wake_output <= next_link_change_detected || next_wake_event_flag;
		end
	end

	// Read-back words
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pmcsr_rdata <= 16'h0000;
			misc_rdata  <= 16'h0000;
		end else begin
			pmcsr_rdata <= 16'h0000;
			pmcsr_rdata[WES_PMCSR_WAKE_FLAG] <= next_wake_event_flag;
			pmcsr_rdata[WES_PMCSR_PIN_EN]    <= next_wake_pin_enable;
			pmcsr_rdata[WES_PMCSR_STATE_LSB +: WES_PMCSR_STATE_W] <= next_power_state;
			misc_rdata <= 16'h0000;
			misc_rdata[WES_MISC_PATTERN_FLAG] <= next_pattern_match_flag;
			misc_rdata[WES_MISC_LINK_MODE]    <= next_link_change_mode;
			misc_rdata[WES_MISC_LINK_FLAG]    <= next_link_change_detected;
			misc_rdata[WES_MISC_OVERRIDE]     <= next_wake_enable_override;
		end
	end

	default clocking wes_cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence clear_and_d0_s;
		pmcsr_write.wr && !pmcsr_write.data[WES_PMCSR_WAKE_FLAG]
			&& pmcsr_write.data[WES_PMCSR_STATE_LSB +: WES_PMCSR_STATE_W] == WES_STATE_D0
			&& !events.magic_detect && !pattern_event && !link_event;
	endsequence

	sequence device_woken_s;
		power_state == WES_STATE_D0 && !wake_event_flag && !pme_oe;
	endsequence

	sequence link_toggle_s;
		link_change_mode && events.mii_mode ##1 link_edge && link_change_mode && events.mii_mode;
	endsequence

	magic_sets_flag_a: assert property (events.magic_detect |=> wake_event_flag)
		else $error("magic event did not set wake flag");

	pattern_mii_only_a: assert property ($rose(pattern_match_flag)
		|-> $past(events.pattern_detect && events.mii_mode) ##0 wake_event_flag)
		else $error("pattern flag rose without MII pattern event");

	link_mii_only_a: assert property ($rose(link_change_detected)
		|-> $past(link_change_mode && events.mii_mode && link_edge))
		else $error("link flag rose without enabled MII link edge");

	pin_enable_write_a: assert property (pmcsr_write.wr
		|=> wake_pin_enable == $past(pmcsr_write.data[WES_PMCSR_PIN_EN]))
		else $error("wake pin enable not taken from write");

	pme_drive_a: assert property (wake_event_flag && wake_pin_enable |-> pme_oe && !pme_out)
		else $error("PME not driven with flag and enable");

	pme_clear_a: assert property (pmcsr_write.wr && !pmcsr_write.data[WES_PMCSR_WAKE_FLAG]
		&& !events.magic_detect && !pattern_event && !link_event
		|=> !wake_event_flag ##0 !pme_oe)
		else $error("clear write left flag or PME set");

	clear_with_d0_a: assert property (clear_and_d0_s |=> device_woken_s)
		else $error("combined clear and D0 write failed");

	link_change_wake_a: assert property (link_toggle_s
		|=> link_change_detected && wake_event_flag && remote_wake_output)
		else $error("link change did not raise flags and remote wake");

	override_pme_a: assert property (wake_event_flag && link_change_detected
		&& wake_enable_override |-> pme_oe)
		else $error("override did not drive PME on link change");

	flag_sticky_a: assert property (wake_event_flag && !wake_clear |=> wake_event_flag)
		else $error("wake flag dropped without clear");

	remote_wake_a: assert property (wake_event_flag |-> remote_wake_output)
		else $error("remote wake not asserted with wake flag");

	pattern_sets_flag_a: assert property (pattern_event
		|=> pattern_match_flag && wake_event_flag)
		else $error("pattern event did not set both flags");

	pattern_flag_sticky_a: assert property (pattern_match_flag
		&& !(misc_write.wr && misc_write.data[WES_MISC_PATTERN_FLAG])
		|=> pattern_match_flag)
		else $error("pattern flag dropped without clear");

	link_flag_sticky_a: assert property (link_change_detected
		&& !(misc_write.wr && misc_write.data[WES_MISC_LINK_FLAG])
		|=> link_change_detected)
		else $error("link flag dropped without clear");

	set_beats_clear_a: assert property (events.magic_detect && wake_clear |=> wake_event_flag)
		else $error("clear won over a same cycle wake event");

	pme_needs_flag_a: assert property (pme_oe |-> wake_event_flag)
		else $error("PME driven without wake flag");

	override_needed_a: assert property (!wake_pin_enable
		&& !wake_enable_override |-> !pme_oe)
		else $error("PME driven with both enables off");

	override_link_only_a: assert property (!wake_pin_enable
		&& !link_change_detected |-> !pme_oe)
		else $error("PME driven by override without link change");

	link_remote_wake_a: assert property (link_change_detected |-> remote_wake_output)
		else $error("remote wake low with link change flag");

	remote_wake_idle_a: assert property (!wake_event_flag
		&& !link_change_detected |-> !remote_wake_output)
		else $error("remote wake high without any flag");

	state_write_a: assert property (pmcsr_write.wr
		|=> power_state == $past(pmcsr_write.data[WES_PMCSR_STATE_LSB +: WES_PMCSR_STATE_W]))
		else $error("power state not taken from write");

	d0_keeps_flag_a: assert property (pmcsr_write.wr && pmcsr_write.data[WES_PMCSR_WAKE_FLAG]
		&& wake_event_flag |=> wake_event_flag)
		else $error("state write without clear dropped wake flag");

	eeprom_mode_load_a: assert property (eeprom_load.wr && !misc_write.wr
		|=> link_change_mode == $past(eeprom_load.data[WES_MISC_LINK_MODE]))
		else $error("link mode not taken from load");

	soft_mode_write_a: assert property (misc_write.wr
		|=> link_change_mode == $past(misc_write.data[WES_MISC_LINK_MODE]))
		else $error("link mode not taken from software write");

	flag_readback_a: assert property (pmcsr_rdata[WES_PMCSR_WAKE_FLAG] == wake_event_flag)
		else $error("wake flag read-back differs from flag");

	link_readback_a: assert property (misc_rdata[WES_MISC_LINK_FLAG] == link_change_detected)
		else $error("link flag read-back differs from flag");

	sequence link_moved_s;
		link_prev_valid && $changed(link_sync) && link_change_mode && events.mii_mode;
	endsequence

	link_edge_wake_a: assert property (link_moved_s
		|=> link_change_detected && wake_event_flag)
		else $error("synced link transition did not set flags");

endmodule

// File: wes_host_model.sv
`timescale 1ns/1ps
module wes_host_model (
	// Device side of the wake line
	input  wire logic pme_out,
	input  wire logic pme_oe,
	// Shared active-low wake line
	output logic      pme_n
);
	// Pull-up holds the line high when nobody drives
	assign pme_n = pme_oe ? pme_out : 1'b1;
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import wes_pkg::*;
	logic                         core_clk;
	logic                         reset;
	wes_events_t                  ev;
	logic                         link;
	wes_cfg_write_t               pmw;
	wes_cfg_write_t               miw;
	wes_cfg_write_t               eel;
	logic [WES_WORD_W-1:0]        pm_rd;
	logic [WES_WORD_W-1:0]        mi_rd;
	logic [WES_PMCSR_STATE_W-1:0] pst;
	logic                         pme_out;
	logic                         pme_oe;
	logic                         rwo;
	logic                         pme_n;
	int                           bad_count;
	int                           n_checks;
	int                           cycles;
	logic [15:0]                  first_wr [3] = '{16'h0100, 16'h8100, 16'h0103};

	wes_wake_event wes_wake_event_inst (.core_clk(core_clk), .reset(reset), .events(ev),
		.link_status(link), .pmcsr_write(pmw), .misc_write(miw), .eeprom_load(eel),
		.pmcsr_rdata(pm_rd), .misc_rdata(mi_rd), .power_state(pst), .pme_out(pme_out),
		.pme_oe(pme_oe), .remote_wake_output(rwo));
	wes_host_model wes_host_model_inst (.pme_out(pme_out), .pme_oe(pme_oe), .pme_n(pme_n));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Each driver lets an edge pass after release, so calls never re-raise at once
	task automatic wr_pm(input logic [15:0] d);
		pmw = '{1'b1, d};
		tick(1);
		pmw.wr = 1'b0;
		tick(1);
	endtask
	task automatic wr_misc(input logic [15:0] d);
		miw = '{1'b1, d};
		tick(1);
		miw.wr = 1'b0;
		tick(1);
	endtask
	task automatic pulse(input logic m, input logic p);
		ev = '{m, p, ev.mii_mode};
		tick(1);
		ev = '{1'b0, 1'b0, ev.mii_mode};
		tick(1);
	endtask
	task automatic toggle_link();
		link = ~link;
		tick(6);
	endtask
	task automatic end_of_test();
		$display("Checks: %0d, mismatches: %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic t_reset();
		check(pm_rd, 16'h0000);
		check(mi_rd, 16'h0000);
		check(16'(pme_n), 16'h1);
		check(16'(rwo), 16'h0);
	endtask
	task automatic t_magic_orders();
		for (int i = 0; i < 3; i++) begin
			wr_pm(16'h8103);
			pulse(1'b1, 1'b0);
			tick(3);
			check(pm_rd, 16'h8103);
			check(16'(pme_n), 16'h0);
			check(16'(rwo), 16'h1);
			wr_pm(first_wr[i]);
			check(pm_rd, first_wr[i]);
			wr_pm(16'h0100);
			check(pm_rd, 16'h0100);
			check(16'(pst), 16'h0);
			check(16'(pme_n), 16'h1);
		end
	endtask
	task automatic t_pin_off();
		wr_pm(16'h0000);
		pulse(1'b1, 1'b0);
		check(pm_rd, 16'h8000);
		check(16'(pme_oe), 16'h0);
		wr_pm(16'h0000);
		check(16'(rwo), 16'h0);
	endtask
	task automatic t_pattern();
		ev.mii_mode = 1'b0;
		tick(1);
		pulse(1'b0, 1'b1);
		check(mi_rd, 16'h0000);
		check(pm_rd, 16'h0000);
		ev.mii_mode = 1'b1;
		tick(1);
		pulse(1'b0, 1'b1);
		check(mi_rd, 16'h0080);
		check(pm_rd, 16'h8000);
		wr_misc(16'h0080);
		wr_pm(16'h0000);
		check(mi_rd, 16'h0000);
	endtask
	task automatic t_link();
		toggle_link();
		check(mi_rd, 16'h0000);
		eel = '{1'b1, 16'h0500};
		tick(1);
		eel.wr = 1'b0;
		check(mi_rd, 16'h0500);
		toggle_link();
		check(mi_rd, 16'h0700);
		check(pm_rd, 16'h8000);
		check(16'(rwo), 16'h1);
		check(16'(pme_oe), 16'h1);
		tick(4);
		check(mi_rd, 16'h0700);
		wr_misc(16'h0700);
		wr_pm(16'h0000);
		check(16'(rwo), 16'h0);
		toggle_link();
		check(mi_rd, 16'h0700);
		wr_misc(16'h0100);
		check(16'(pme_oe), 16'h0);
		wr_misc(16'h0300);
		wr_pm(16'h0000);
		ev.mii_mode = 1'b0;
		toggle_link();
		check(mi_rd, 16'h0100);
	endtask

	task automatic t_reset_mid();
		wr_pm(16'h0100);
		pulse(1'b1, 1'b0);
		check(16'(pme_oe), 16'h1);
		link = 1'b1;
		ev.mii_mode = 1'b1;
		reset = 1'b1;
		tick(5);
		reset = 1'b0;
		tick(1);
		eel = '{1'b1, 16'h0500};
		tick(1);
		eel.wr = 1'b0;
		tick(6);
		check(mi_rd, 16'h0500);
		check(pm_rd, 16'h0000);
		check(16'(pme_oe), 16'h0);
		check(16'(rwo), 16'h0);
	endtask
	task automatic t_soft_mode();
		wr_misc(16'h0000);
		toggle_link();
		check(mi_rd, 16'h0000);
		wr_misc(16'h0100);
		toggle_link();
		check(mi_rd, 16'h0300);
		check(pm_rd, 16'h8000);
		wr_misc(16'h0200);
		wr_pm(16'h0000);
		check(mi_rd, 16'h0000);
	endtask
	task automatic t_collide();
		pmw = '{1'b1, 16'h0000};
		miw = '{1'b1, 16'h0000};
		eel = '{1'b1, 16'h0500};
		ev = '{1'b1, 1'b0, ev.mii_mode};
		tick(1);
		pmw.wr = 1'b0;
		miw.wr = 1'b0;
		eel.wr = 1'b0;
		ev.magic_detect = 1'b0;
		tick(1);
		check(pm_rd, 16'h8000);
		check(mi_rd, 16'h0000);
		wr_pm(16'h0000);
		check(pm_rd, 16'h0000);
		check(16'(rwo), 16'h0);
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		reset = 1'b1;
		ev = '0;
		link = 1'b0;
		pmw = '0;
		miw = '0;
		eel = '0;
		bad_count = 0;
		n_checks = 0;
		cycles = 0;
		tick(5);
		reset = 1'b0;
		tick(4);
		t_reset();
		t_magic_orders();
		t_pin_off();
		t_pattern();
		t_link();
		t_reset_mid();
		t_soft_mode();
		t_collide();
		end_of_test();
	end
endmodule
